// *** src/dacwl_map.svh ***
/*
  Constants of the serial word loader: frame lengths, field positions inside
  a received word, code masks and reset values.
  Assumes it is included by its bare name before the dacwl_pkg package.
*/
`ifndef DACWL_MAP_SVH
`define DACWL_MAP_SVH

// Frame lengths in falling serial-clock edges
`define DACWL_FRAME_SHORT   5'h10
`define DACWL_FRAME_LONG    5'h18

// Shift register width, long enough for the longest frame
`define DACWL_SHIFT_W       24

// Top bit of the two power-down control bits, per resolution variant
`define DACWL_PD_TOP_12     13
`define DACWL_PD_TOP_14     15
`define DACWL_PD_TOP_16     17

// Data fields, right aligned in the low bits of the word
`define DACWL_CODE_MASK_12  16'h0FFF
`define DACWL_CODE_MASK_14  16'h3FFF
`define DACWL_CODE_MASK_16  16'hFFFF

// Values after power-up: zero code, normal drive
`define DACWL_RESET_CODE    16'h0000
`define DACWL_RESET_PD      2'h0

// Power-down control encodings
`define DACWL_PD_NORMAL     2'h0
`define DACWL_PD_1K         2'h1
`define DACWL_PD_100K       2'h2
`define DACWL_PD_HIZ        2'h3

// Resolution variants
`define DACWL_RES_12        12
`define DACWL_RES_14        14
`define DACWL_RES_16        16

`endif

// *** src/dacwl_pkg.sv ***
/*
  Types and helper functions of the serial word loader.
  Assumes dacwl_map.svh for every numeric constant except the state encodings.
*/
`include "dacwl_map.svh"

package dacwl_pkg;

  // Output stage selection decoded from the two control bits
  typedef enum logic [1:0]
  {
    DACWL_MODE_NORMAL = `DACWL_PD_NORMAL,
    DACWL_MODE_1K     = `DACWL_PD_1K,
    DACWL_MODE_100K   = `DACWL_PD_100K,
    DACWL_MODE_HIZ    = `DACWL_PD_HIZ
  } dacwl_mode_t;

  // Input buffer state on the system clock, Gray coded along the frame path
  typedef enum logic [1:0]
  {
    DACWL_ST_IDLE  = 2'h0,
    DACWL_ST_FRAME = 2'h1,
    DACWL_ST_HELD  = 2'h3
  } dacwl_state_t;

  // Frame length in edges for a resolution variant
  function automatic logic [4:0] dacwl_frame_len(input int res);
    dacwl_frame_len = (res == `DACWL_RES_16) ? `DACWL_FRAME_LONG : `DACWL_FRAME_SHORT;
  endfunction

endpackage

// *** src/dacwl_sync.sv ***
/*
  Two flip-flop level synchroniser, one bit per lane.
  Assumes each input lane is a level that stays put for several destination
  clocks; the first stage feeds only the second.
*/
`timescale 1ns/1ps

module dacwl_sync
#(
  parameter int WIDTH = 1
)
(
  // Destination clock and reset
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  // Levels from another domain
  input  wire logic [WIDTH-1:0] async_i,
  // Levels safe to use in the destination domain
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_one;

  // First stage read by the second stage only
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage_one <= '0;
      sync_o    <= '0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end

endmodule

// *** src/dacwl_mode_dec.sv ***
/*
  Registered decode of the two power-down control bits into the controls of
  the analog output stage.
  Assumes the control bits change only when a new word is loaded.
*/
`timescale 1ns/1ps

module dacwl_mode_dec
  import dacwl_pkg::*;
(
  // System clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  // Control bits of the loaded word
  input  wire logic [1:0] pwrdn_sel_i,
  // Output stage controls
  output logic            amp_drive_o,
  output logic            pulldown_1k_o,
  output logic            pulldown_100k_o
);

  dacwl_mode_t mode;

  assign mode = dacwl_mode_t'(pwrdn_sel_i);

  // At most one stage control high, none for high-Z; at power-up the amplifier drives the zero code
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      amp_drive_o     <= 1'b1;
      pulldown_1k_o   <= 1'b0;
      pulldown_100k_o <= 1'b0;
    end
    else
    begin
      amp_drive_o     <= (mode == DACWL_MODE_NORMAL);      // see [R11]
      pulldown_1k_o   <= (mode == DACWL_MODE_1K);          // see [R11]
      pulldown_100k_o <= (mode == DACWL_MODE_100K);        // see [R11]
    end
  end

endmodule

// *** src/dacwl_loader.sv ***
/*
  Serial word loader of a single-channel voltage-output converter: the
  frame-select / serial-clock / data front end, the crossing into the system
  clock, the DAC register and the output stage controls.
  Assumes the host drives the serial clock only inside frames, holds frame
  select high at least 20 ns between frames, and that the system clock runs
  at 20 MHz while the serial clock may run up to 30 MHz.
*/
// What this block does
// [R1] Low frame select opens a word; only bits taken while low belong to it.
// [R2] While select is low the shift register takes data on falling clock edges.
// [R3] Data sampled into a 24 bit shift register on each falling edge up to the last one of the frame, for every variant.
// [R4] DAC register updates on the third system-clock edge after the sixteenth or twenty-fourth counted edge.
// [R5] Select rising before the last edge aborts; DAC register stays unchanged.
// [R6] Word is 16 bits for 12/14 bit variants, 24 bits for 16 bit.
// [R7] Clock and data input buffers switch off after a complete frame.
// [R8] Most significant bit first; first bit lands in the top position.
// [R9] Power-up forces the output to zero code.
// [R10] Shift register separate from DAC register; DAC loads only on full frames.
// [R11] Two control bits select normal, 1k pull-down, 100k pull-down or high-Z.
// [R12] The two control bits precede the data bits in each word.
// [R13] After power-up DAC register holds zeros until the first complete write.
// [R14] Extra edges after the last one are ignored until select is raised again.
`timescale 1ns/1ps
`include "dacwl_map.svh"

module dacwl_loader
  import dacwl_pkg::*;
#(
  parameter int RESOLUTION = `DACWL_RES_16
)
(
  // System clock and power-on reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  // Serial port pins from the host
  input  wire logic        sclk_i,
  input  wire logic        frame_sel_n_i,
  input  wire logic        din_i,
  // Converter controls
  output logic      [15:0] dac_code_o,
  output logic             pwrdn_sel_hi_o,
  output logic             pwrdn_sel_lo_o,
  output logic             dac_update_o,
  // Analog output stage controls for analog_output
  output logic             amp_drive_o,
  output logic             pulldown_1k_o,
  output logic             pulldown_100k_o,
  // Input buffer enable for the serial clock and data pins
  output logic             inbuf_en_o
);

  // Frame length of the variant; the counter starts at zero, so the word
  // completes on the edge that finds the counter at LAST_EDGE
  localparam logic [4:0] FRAME_LEN = dacwl_frame_len(RESOLUTION);         // see [R6]
  localparam logic [4:0] LAST_EDGE = FRAME_LEN - 5'h01;
  // Control bits after power-up, split per bit for the one-bit outputs
  localparam logic [1:0] RESET_PD  = `DACWL_RESET_PD;

  // ---------------------------------------------------------------------
  // Link domain, clocked by falling serial-clock edges
  // ---------------------------------------------------------------------

  logic                      link_rst_n;
  logic [4:0]                bit_cnt;
  logic [`DACWL_SHIFT_W-1:0] shift_reg;
  logic                      frame_done;
  logic [`DACWL_SHIFT_W-1:0] next_shift;
  logic                      last_edge;
  logic [`DACWL_SHIFT_W-1:0] hold_word;
  logic                      word_toggle;

  // The serial clock stands still outside frames, so the frame ends itself:
  // a high select holds the link counter in reset without needing an edge
  assign link_rst_n = reset_n_i & ~frame_sel_n_i;              // see [R1] see [R5]

  // Shift left so the first bit of the frame ends at the top of the word
  assign next_shift = {shift_reg[`DACWL_SHIFT_W-2:0], din_i};  // see [R8] see [R12]
  assign last_edge  = !frame_done && (bit_cnt == LAST_EDGE);   // see [R4]

  // Edge counter and shift register; they live only while select is low
  always_ff @(negedge sclk_i or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt    <= 5'h00;
      shift_reg  <= '0;
      frame_done <= 1'b0;
    end
    else if (!frame_done)                                      // see [R14]
    begin
      shift_reg <= next_shift;                                 // see [R2] see [R3]
      bit_cnt   <= bit_cnt + 5'h01;
      if (last_edge)
      begin
        frame_done <= 1'b1;                                    // see [R7] see [R14]
      end
    end
  end

  // Completed word, kept apart from the shifter and stable until the next
  // completed frame, so the system side can read it after the toggle
  always_ff @(negedge sclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hold_word   <= '0;
      word_toggle <= 1'b0;
    end
    else if (last_edge && !frame_sel_n_i)                      // see [R5] see [R10]
    begin
      hold_word   <= next_shift;
      word_toggle <= ~word_toggle;                             // see [R4]
    end
  end

  // ---------------------------------------------------------------------
  // Crossing into the system clock
  // ---------------------------------------------------------------------

  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic       toggle_sync;
  logic       done_sync;
  logic       sel_low_sync;
  logic       toggle_seen;
  logic       word_event;

  assign sync_in = {word_toggle, frame_done, ~frame_sel_n_i};

  dacwl_sync
  #(
    .WIDTH (3)
  )
  u_sync
  (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   (sync_in),
    .sync_o    (sync_out)
  );

  assign toggle_sync  = sync_out[2];
  assign done_sync    = sync_out[1];
  assign sel_low_sync = sync_out[0];

  // Edge of the synchronised toggle marks one completed word
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      toggle_seen <= 1'b0;
    end
    else
    begin
      toggle_seen <= toggle_sync;
    end
  end

  assign word_event = toggle_sync ^ toggle_seen;

  // ---------------------------------------------------------------------
  // DAC register
  // ---------------------------------------------------------------------

  logic [15:0] next_code;
  logic [1:0]  next_pd;

  // Field split by variant: control bits first, data right aligned below
  always_comb
  begin
    next_code = hold_word[15:0];
    next_pd   = `DACWL_RESET_PD;
    if (RESOLUTION == `DACWL_RES_12)
    begin
      next_code = hold_word[15:0] & `DACWL_CODE_MASK_12;                   // see [R12]
      next_pd   = hold_word[`DACWL_PD_TOP_12 -: 2];                        // see [R11]
    end
    else if (RESOLUTION == `DACWL_RES_14)
    begin
      next_code = hold_word[15:0] & `DACWL_CODE_MASK_14;                   // see [R12]
      next_pd   = hold_word[`DACWL_PD_TOP_14 -: 2];                        // see [R11]
    end
    else
    begin
      next_code = hold_word[15:0] & `DACWL_CODE_MASK_16;                   // see [R12]
      next_pd   = hold_word[`DACWL_PD_TOP_16 -: 2];                        // see [R11]
    end
  end

  // Loaded only on a completed frame; aborted frames never toggle
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dac_code_o     <= `DACWL_RESET_CODE;                     // see [R9] see [R13]
      pwrdn_sel_hi_o <= RESET_PD[1];                           // see [R9]
      pwrdn_sel_lo_o <= RESET_PD[0];                           // see [R9]
    end
    else if (word_event)                                       // see [R10]
    begin
      dac_code_o     <= next_code;                             // see [R4]
      pwrdn_sel_hi_o <= next_pd[1];                            // see [R11]
      pwrdn_sel_lo_o <= next_pd[0];                            // see [R11]
    end
  end

  // One-cycle strobe telling the converter a new code stands
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dac_update_o <= 1'b0;
    end
    else
    begin
      dac_update_o <= word_event;                              // see [R4]
    end
  end

  // Output stage follows the registered control bits
  dacwl_mode_dec u_mode_dec
  (
    .clock_i         (clock_i),
    .reset_n_i       (reset_n_i),
    .pwrdn_sel_i     ({pwrdn_sel_hi_o, pwrdn_sel_lo_o}),
    .amp_drive_o     (amp_drive_o),
    .pulldown_1k_o   (pulldown_1k_o),
    .pulldown_100k_o (pulldown_100k_o)
  );

  // ---------------------------------------------------------------------
  // Input buffer control
  // ---------------------------------------------------------------------

  dacwl_state_t buf_state;
  dacwl_state_t next_buf_state;

  // Buffers wake on select low and sleep once the frame is complete; the
  // enable lags the pins by the synchroniser, so the first bits of a frame
  // are taken by the link logic regardless of this output
  always_comb
  begin
    next_buf_state = buf_state;
    unique case (buf_state)
      DACWL_ST_IDLE:
      begin
        if (sel_low_sync)
        begin
          next_buf_state = DACWL_ST_FRAME;                     // see [R7]
        end
      end
      DACWL_ST_FRAME:
      begin
        if (!sel_low_sync)
        begin
          next_buf_state = DACWL_ST_IDLE;                      // see [R5]
        end
        else if (done_sync)
        begin
          next_buf_state = DACWL_ST_HELD;                      // see [R7]
        end
      end
      DACWL_ST_HELD:
      begin
        if (!sel_low_sync)
        begin
          next_buf_state = DACWL_ST_IDLE;                      // see [R14]
        end
      end
      default:
      begin
        next_buf_state = DACWL_ST_IDLE;
      end
    endcase
  end

  // State register of the buffer control
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      buf_state <= DACWL_ST_IDLE;
    end
    else
    begin
      buf_state <= next_buf_state;
    end
  end

  // Registered enable, high only inside an open, unfinished frame
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      inbuf_en_o <= 1'b0;
    end
    else
    begin
      inbuf_en_o <= (next_buf_state == DACWL_ST_FRAME);        // see [R7]
    end
  end

endmodule

// *** sim/dacwl_loader_sva.sv ***
/*
  Checker of the serial word loader, watching only the loader's ports.
  Assumes the system clock domain samples everything, link pins included.
*/
`timescale 1ns/1ps

module dacwl_loader_sva
#(
  parameter int RESOLUTION = 16
)
(
  // System clock and reset
  input wire logic        clock_i,
  input wire logic        reset_n_i,
  // Serial pins
  input wire logic        sclk_i,
  input wire logic        frame_sel_n_i,
  input wire logic        din_i,
  // Converter and stage controls
  input wire logic [15:0] dac_code_o,
  input wire logic        pwrdn_sel_hi_o,
  input wire logic        pwrdn_sel_lo_o,
  input wire logic        dac_update_o,
  input wire logic        amp_drive_o,
  input wire logic        pulldown_1k_o,
  input wire logic        pulldown_100k_o,
  input wire logic        inbuf_en_o
);
  // Control bits as one field
  wire logic [1:0] pd = {pwrdn_sel_hi_o, pwrdn_sel_lo_o};

  // Select is asynchronous here, so bounds are kept a little loose
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  code_hold_a: assert property (!dac_update_o |-> $stable(dac_code_o))
    else $error("code moved without an update");
  mode_hold_a: assert property (!dac_update_o |-> $stable(pd))
    else $error("control bits moved without an update");
  update_pulse_a: assert property (dac_update_o |=> !dac_update_o)
    else $error("update longer than one cycle");
  drive_decode_a: assert property (!dac_update_o |-> amp_drive_o == (pd == 2'h0))
    else $error("amplifier drive wrong for mode");
  pull_1k_a: assert property (!dac_update_o |-> pulldown_1k_o == (pd == 2'h1))
    else $error("1k pull-down wrong for mode");
  pull_100k_a: assert property (!dac_update_o |-> pulldown_100k_o == (pd == 2'h2))
    else $error("100k pull-down wrong for mode");
  buf_idle_a: assert property (frame_sel_n_i [*6] |-> !inbuf_en_o)
    else $error("input buffers on outside a frame");
  buf_open_a: assert property ($fell(frame_sel_n_i) |-> ##[1:6] inbuf_en_o)
    else $error("input buffers not enabled by select");
  buf_close_a: assert property ($rose(dac_update_o) |-> ##[0:4] !inbuf_en_o)
    else $error("input buffers left on after a frame");

  // Main scenarios
  cover property (dac_update_o && pd == 2'h3);
  cover property ($fell(inbuf_en_o) && !frame_sel_n_i);
  cover property ($rose(frame_sel_n_i) && inbuf_en_o);
endmodule

bind dacwl_loader dacwl_loader_sva #(.RESOLUTION(RESOLUTION)) dacwl_loader_sva_inst
(
  .clock_i, .reset_n_i, .sclk_i, .frame_sel_n_i, .din_i, .dac_code_o, .pwrdn_sel_hi_o,
  .pwrdn_sel_lo_o, .dac_update_o, .amp_drive_o, .pulldown_1k_o, .pulldown_100k_o, .inbuf_en_o
);

// *** sim/dacwl_host.sv ***
/*
  Host model driving the three-wire serial port of the loader.
  Assumes words arrive left aligned in 24 bits; 32 ns serial clock period.
*/
`timescale 1ns/1ps

module dacwl_host
(
  // Serial pins toward the loader
  output logic sclk_o,
  output logic frame_sel_n_o,
  output logic din_o
);
  // Idle: clock still, select high
  initial
  begin
    sclk_o        = 1'b0;
    frame_sel_n_o = 1'b1;
    din_o         = 1'b0;
  end

  // One frame, then extra edges with select still low; short nbits aborts
  task automatic send(input logic [23:0] word, input int nbits, input int extra);
    frame_sel_n_o = 1'b0;
    #16;
    for (int i = 0; i < nbits + extra; i++)
    begin
      sclk_o = 1'b1;
      din_o  = (i < nbits) ? word[23 - i] : ~din_o;
      #16 sclk_o = 1'b0;
      #16;
    end
    frame_sel_n_o = 1'b1;
    // Released data never shows a stale bit
    din_o = ~din_o;
  endtask
endmodule

// *** sim/dacwl_loader_test.sv ***
/*
  Self-checking bench of the serial word loader, 16-bit variant.
  Assumes the host model makes the serial clock only inside frames.
*/
`timescale 1ns/1ps

module dacwl_loader_test;
  logic        clock_i = 1'b0;
  logic        reset_n_i;
  logic        sclk;
  logic        frame_sel_n;
  logic        din;
  logic [15:0] dac_code;
  logic        pd_hi;
  logic        pd_lo;
  logic        upd;
  logic [2:0]  stage;
  logic        inbuf;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          updates = 0;
  logic [15:0] codes [4] = '{16'h8001, 16'h7FFE, 16'hA5C3, 16'hFFFF};

  dacwl_loader #(.RESOLUTION(16)) dacwl_loader_inst
  (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .frame_sel_n_i(frame_sel_n),
    .din_i(din), .dac_code_o(dac_code), .pwrdn_sel_hi_o(pd_hi), .pwrdn_sel_lo_o(pd_lo),
    .dac_update_o(upd), .amp_drive_o(stage[2]), .pulldown_1k_o(stage[1]),
    .pulldown_100k_o(stage[0]), .inbuf_en_o(inbuf)
  );

  dacwl_host dacwl_host_inst (.sclk_o(sclk), .frame_sel_n_o(frame_sel_n), .din_o(din));

  // 20 MHz system clock
  always #25 clock_i = ~clock_i;

  // Count update pulses; cut a hang short
  always @(posedge clock_i)
  begin
    cycles++;
    if (upd === 1'b1)
      updates++;
    if (cycles == 5000)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] expected);
    total_checks++;
    if (seen !== expected)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Send a frame, let the crossing settle, compare the update count
  task automatic run_frame(input logic [23:0] word, input int nbits, input int n_upd);
    int n0;
    n0 = updates;
    dacwl_host_inst.send(word, nbits, 0);
    repeat (12) @(negedge clock_i);
    check(updates - n0, n_upd);
  endtask

  task automatic t_reset();
    @(negedge clock_i);
    check({dac_code, pd_hi, pd_lo, upd, stage, inbuf}, {16'h0000, 3'h0, 3'h4, 1'b0});
  endtask

  // Power-on reset in mid-run must clear a loaded code again
  task automatic t_midreset();
    @(negedge clock_i);
    reset_n_i = 1'b0;
    repeat (3) @(negedge clock_i);
    reset_n_i = 1'b1;
    @(negedge clock_i);
    check({dac_code, pd_hi, pd_lo, upd, stage, inbuf}, {16'h0000, 3'h0, 3'h4, 1'b0});
  endtask

  // Every mode, with junk in the ignored top bits
  task automatic t_modes();
    for (int k = 0; k < 4; k++)
    begin
      run_frame({6'h2A, k[1:0], codes[k]}, 24, 1);
      check(dac_code, codes[k]);
      check({pd_hi, pd_lo}, k[1:0]);
      check(stage, {k == 0, k == 1, k == 2});
    end
  endtask

  // Aborts, the last one a single edge short
  task automatic t_abort();
    run_frame(24'h005A5A, 10, 0);
    run_frame(24'h005A5A, 23, 0);
    check(dac_code, codes[3]);
    check({pd_hi, pd_lo, inbuf}, 3'h6);
  endtask

  // Extra edges after the last one, select held low
  task automatic t_extra();
    int n0;
    n0 = updates;
    fork
      dacwl_host_inst.send(24'h001234, 24, 16);
      begin
        repeat (22) @(negedge clock_i);
        check({frame_sel_n, inbuf}, 2'h0);
      end
    join
    repeat (12) @(negedge clock_i);
    check(updates - n0, 1);
    check(dac_code, 16'h1234);
  endtask

  initial
  begin
    reset_n_i = 1'b0;
    repeat (12) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_reset();
    t_modes();
    t_abort();
    t_extra();
    t_midreset();
    print_verdict();
  end
endmodule
